// ---- hw/startup_cal_regs.svh ----
// register map, field positions and timing counts of the startup calibration block
// Notes on behaviour
// - hot/cold adjust bytes are sign-magnitude, seven bits
// - auto-zero done after 3352 link clock cycles
// - done flag cleared by writing one
// - eleven-bit offset results per gain readable
// - temperature outside limits raises calibration request
`ifndef STARTUP_CAL_REGS_SVH
`define STARTUP_CAL_REGS_SVH
`define OFS_COMPENSATION_CONTROL 8'ha0
`define OFS_COMP_STAT 8'ha2
`define OFS_VOFS 8'haa
`define OFS_TOFS 8'hd0
`define OFS_TGAIN 8'hd1
`define OFS_TEMP_MAX 8'hc0
`define OFS_TEMP_MIN 8'hc2
`define OFS_IRQ_STAT 8'hc4
`define OFS_IRQ_MASK 8'hc5
`define OFS_RESULT_BASE 8'hb0
`define OFS_ADJ_IN 8'hc6
`define OFS_ADJ_OUT 8'hc7
`define BIT_AZ_REQ 0
`define BIT_AZ_MASK 8
`define BIT_DONE 0
`define BIT_IRQ_DONE 0
`define BIT_IRQ_CAL 1
`define NUM_GAINS 8
`define AZ_CYCLES 3352
`define LINK_DIV 6'd48
`endif

// ---- hw/startup_cal_pkg.sv ----
// types shared by the startup calibration block
package startup_cal_pkg;
   typedef enum logic [1:0] {AZ_IDLE, AZ_RUN, AZ_DONE} az_state_e;
   typedef logic [10:0] result_t;
endpackage

// ---- hw/startup_cal.sv ----
// startup calibration: compensation registers, auto-zero sequencer, calibration limit interrupt
//
// The plain strobed port was chosen for this implementation.
`include "startup_cal_regs.svh"
`timescale 1ns/100ps
module startup_cal
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic [15:0] temperature,
   input wire logic temperature_valid,
   input wire logic [10:0] amp_offset_measured,
   output logic autozero_active,
   output logic [7:0] voltage_offset_compensation,
   output logic [7:0] temperature_offset_compensation,
   output logic [7:0] temperature_gain_compensation,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////
   // signed view of a stored adjust byte, sign in bit 7
   function automatic logic [8:0] sm_to_twos(input logic [7:0] v);
      logic [8:0] mag;
      mag = {2'h0, v[6:0]};
      sm_to_twos = v[7] ? 9'((~mag) + 9'h001) : mag;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register state
   logic az_req_q, az_req_d;
   logic done_q, done_d;
   logic [7:0] vofs_q, vofs_d, tofs_q, tofs_d, tgain_q, tgain_d;
   logic [15:0] tmax_q, tmax_d, tmin_q, tmin_d;
   logic [1:0] ists_q, ists_d, imask_q, imask_d;
   logic [7:0] adj_q, adj_d;
   logic [15:0] rdata_q, rdata_d;
   startup_cal_pkg::result_t res_q [`NUM_GAINS];
   startup_cal_pkg::result_t res_d [`NUM_GAINS];
   startup_cal_pkg::az_state_e st_q, st_d;
   logic [11:0] cnt_q, cnt_d;
   logic [5:0] div_q, div_d;
   logic [2:0] gidx_q, gidx_d;
   logic done_evt;
   logic cal_evt;
   logic link_tick;

   ////////////////////////////////////////////////////////////////////////
   // divider models the 512 kHz die link clock as a tick from the 25 MHz clock
   // 25 MHz / 48 is about 521 kHz; the ratio is not integral, so timing runs slightly fast
   assign link_tick = (div_q == (`LINK_DIV - 6'd1));

   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      div_d = link_tick ? 6'h00 : 6'(div_q + 6'h01);
      gidx_d = gidx_q;
      done_evt = 1'b0;
      for (int i = 0; i < `NUM_GAINS; i++)
      begin
         res_d[i] = res_q[i];
      end
      case (st_q)
         startup_cal_pkg::AZ_IDLE:
         begin
            cnt_d = 12'h000;
            gidx_d = 3'h0;
            if (az_req_q)
            begin
               st_d = startup_cal_pkg::AZ_RUN;
            end
         end
         startup_cal_pkg::AZ_RUN:
         begin
            if (link_tick)
            begin
               cnt_d = 12'(cnt_q + 12'h001);
               // spread one measurement per gain across the sequence: ticks 0, 512 .. 3072 fill gains 0..6
               if (cnt_q[8:0] == 9'h000)
               begin
                  res_d[gidx_q] = amp_offset_measured;
                  gidx_d = 3'(gidx_q + 3'h1);
               end
               if (cnt_q == 12'(`AZ_CYCLES - 1))
               begin
                  res_d[`NUM_GAINS - 1] = amp_offset_measured;
                  st_d = startup_cal_pkg::AZ_DONE;
                  done_evt = 1'b1;
               end
            end
         end
         startup_cal_pkg::AZ_DONE:
         begin
            // wait for software to leave auto-zero mode before another run
            if (!az_req_q)
            begin
               st_d = startup_cal_pkg::AZ_IDLE;
            end
         end
         default:
         begin
            st_d = startup_cal_pkg::AZ_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // calibration request when temperature leaves the window
   assign cal_evt = temperature_valid && ((temperature > tmax_q) || (temperature < tmin_q));

   always_comb
   begin
      az_req_d = az_req_q;
      done_d = done_q;
      vofs_d = vofs_q;
      tofs_d = tofs_q;
      tgain_d = tgain_q;
      tmax_d = tmax_q;
      tmin_d = tmin_q;
      ists_d = ists_q;
      imask_d = imask_q;
      adj_d = adj_q;
      // writes to offsets outside the map fall through and change nothing
      if (wr)
      begin
         // a write without the mask bit leaves the request alone
         if (hit(addr, `OFS_COMPENSATION_CONTROL) && wdata[`BIT_AZ_MASK])
         begin
            az_req_d = wdata[`BIT_AZ_REQ];
         end
         if (hit(addr, `OFS_COMP_STAT) && wdata[`BIT_DONE])
         begin
            done_d = 1'b0;
         end
         if (hit(addr, `OFS_VOFS))
         begin
            vofs_d = wdata[7:0];
         end
         if (hit(addr, `OFS_TOFS))
         begin
            tofs_d = wdata[7:0];
         end
         if (hit(addr, `OFS_TGAIN))
         begin
            tgain_d = wdata[7:0];
         end
         if (hit(addr, `OFS_TEMP_MAX))
         begin
            tmax_d = wdata;
         end
         if (hit(addr, `OFS_TEMP_MIN))
         begin
            tmin_d = wdata;
         end
         if (hit(addr, `OFS_IRQ_STAT))
         begin
            ists_d = ists_q & ~wdata[1:0];
         end
         if (hit(addr, `OFS_IRQ_MASK))
         begin
            imask_d = wdata[1:0];
         end
         if (hit(addr, `OFS_ADJ_IN))
         begin
            adj_d = wdata[7:0];
         end
      end
      // set wins over a clear in the same cycle, so no completion is ever lost
      if (done_evt)
      begin
         done_d = 1'b1;
      end
      ists_d[`BIT_IRQ_DONE] = ists_d[`BIT_IRQ_DONE] | done_evt;
      ists_d[`BIT_IRQ_CAL] = ists_d[`BIT_IRQ_CAL] | cal_evt;
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux: reads have no side effects, flags clear only by explicit writes
   // unmapped offsets and idle cycles return zero
   always_comb
   begin
      rdata_d = 16'h0000;
      if (rd)
      begin
         if (hit(addr, `OFS_COMPENSATION_CONTROL))
         begin
            rdata_d = {15'h0000, az_req_q};
         end
         else if (hit(addr, `OFS_COMP_STAT))
         begin
            rdata_d = {15'h0000, done_q};
         end
         else if (hit(addr, `OFS_VOFS))
         begin
            rdata_d = {8'h00, vofs_q};
         end
         else if (hit(addr, `OFS_TOFS))
         begin
            rdata_d = {8'h00, tofs_q};
         end
         else if (hit(addr, `OFS_TGAIN))
         begin
            rdata_d = {8'h00, tgain_q};
         end
         else if (hit(addr, `OFS_TEMP_MAX))
         begin
            rdata_d = tmax_q;
         end
         else if (hit(addr, `OFS_TEMP_MIN))
         begin
            rdata_d = tmin_q;
         end
         else if (hit(addr, `OFS_IRQ_STAT))
         begin
            rdata_d = {14'h0000, ists_q};
         end
         else if (hit(addr, `OFS_IRQ_MASK))
         begin
            rdata_d = {14'h0000, imask_q};
         end
         else if (hit(addr, `OFS_ADJ_IN))
         begin
            rdata_d = {8'h00, adj_q};
         end
         else if (hit(addr, `OFS_ADJ_OUT))
         begin
            rdata_d = {7'h00, sm_to_twos(adj_q)};
         end
         else if ((addr >= `OFS_RESULT_BASE) && (addr < 8'(`OFS_RESULT_BASE + `NUM_GAINS)))
         begin
            rdata_d = {5'h00, res_q[addr[2:0]]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_q <= startup_cal_pkg::AZ_IDLE;
         cnt_q <= 12'h000;
         div_q <= 6'h00;
         gidx_q <= 3'h0;
         az_req_q <= 1'b0;
         done_q <= 1'b0;
         vofs_q <= 8'h00;
         tofs_q <= 8'h00;
         tgain_q <= 8'h00;
         tmax_q <= 16'hffff;
         tmin_q <= 16'h0000;
         ists_q <= 2'h0;
         imask_q <= 2'h0;
         adj_q <= 8'h00;
         rdata_q <= 16'h0000;
         for (int i = 0; i < `NUM_GAINS; i++)
         begin
            res_q[i] <= 11'h000;
         end
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         div_q <= div_d;
         gidx_q <= gidx_d;
         az_req_q <= az_req_d;
         done_q <= done_d;
         vofs_q <= vofs_d;
         tofs_q <= tofs_d;
         tgain_q <= tgain_d;
         tmax_q <= tmax_d;
         tmin_q <= tmin_d;
         ists_q <= ists_d;
         imask_q <= imask_d;
         adj_q <= adj_d;
         rdata_q <= rdata_d;
         for (int i = 0; i < `NUM_GAINS; i++)
         begin
            res_q[i] <= res_d[i];
         end
      end
   end

   assign rdata = rdata_q;
   assign autozero_active = (st_q == startup_cal_pkg::AZ_RUN);
   assign voltage_offset_compensation = vofs_q;
   assign temperature_offset_compensation = tofs_q;
   assign temperature_gain_compensation = tgain_q;
   assign irq = |(ists_q & imask_q);
endmodule

// ---- testbench/afe_model.sv ----
// analog front end stand-in for the auto-zero offset
`timescale 1ns/100ps
module afe_model
(
   input wire logic autozero_active,
   output logic [10:0] amp_offset_measured
);
   // outside a run the value flips, so a stale capture cannot match
   assign amp_offset_measured = autozero_active ? 11'h2a5 : 11'h55a;
endmodule

// ---- testbench/startup_cal_assertions.sv ----
// port checker for the startup calibration block
`timescale 1ns/100ps
`include "startup_cal_regs.svh"
module startup_cal_checker
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic autozero_active,
   input wire logic [7:0] voltage_offset_compensation,
   input wire logic [7:0] temperature_offset_compensation,
   input wire logic [7:0] temperature_gain_compensation,
   input wire logic irq
);
   localparam int AZ_LO = 160800;
   localparam int AZ_HI = 161000;
   logic [17:0] run_q;
   logic [17:0] run_d;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   always_comb run_d = autozero_active ? run_q + 18'h00001 : 18'h00000;
   always_ff @(posedge clk) run_q <= reset ? 18'h00000 : run_d;
   sequence az_req;
      wr && addr == `OFS_COMPENSATION_CONTROL && wdata[8] && wdata[0];
   endsequence
   sequence az_hold;
      autozero_active [*8];
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   chk_az_start: assert property ($rose(autozero_active) |-> $past(wr && addr == `OFS_COMPENSATION_CONTROL && wdata[8] && wdata[0], 2))
      else $error("auto-zero began without a request");
   chk_az_runs: assert property (az_req ##2 $rose(autozero_active) |-> az_hold)
      else $error("auto-zero stopped early");
   chk_az_masked: assert property (wr && addr == `OFS_COMPENSATION_CONTROL && !wdata[8] && !autozero_active |=> !autozero_active)
      else $error("unmasked write started auto-zero");
   chk_az_length: assert property ($fell(autozero_active) |-> run_q inside {[AZ_LO:AZ_HI]})
      else $error("auto-zero run length wrong");
   chk_rd_quiet: assert property (!rd |=> rdata == 16'h0000)
      else $error("read data without a read");
   chk_vofs_copy: assert property (wr && addr == `OFS_VOFS |-> ##2 voltage_offset_compensation == $past(wdata[7:0], 2))
      else $error("voltage offset not applied");
   chk_tofs_copy: assert property (wr && addr == `OFS_TOFS |-> ##2 temperature_offset_compensation == $past(wdata[7:0], 2))
      else $error("temperature offset not applied");
   chk_tgain_copy: assert property (wr && addr == `OFS_TGAIN |-> ##2 temperature_gain_compensation == $past(wdata[7:0], 2))
      else $error("temperature gain not applied");
   chk_irq_masked: assert property (wr && addr == `OFS_IRQ_MASK && wdata[1:0] == 2'b00 |-> ##2 !irq)
      else $error("interrupt high while masked");
endmodule
bind startup_cal startup_cal_checker chk (.*);

// ---- testbench/startup_cal_test.sv ----
// self-checking bench for the startup calibration block
`timescale 1ns/100ps
`include "startup_cal_regs.svh"
module startup_cal_test;
   logic clk, reset, wr, rd, temperature_valid, irq, autozero_active;
   logic [7:0] addr, voltage_offset_compensation, temperature_offset_compensation, temperature_gain_compensation;
   logic [15:0] wdata, rdata, temperature, v;
   logic [10:0] amp_offset_measured;
   int n_mismatch = 0, compares = 0, cycles = 0, i, t0;
   logic [7:0] adj [4] = '{8'h82, 8'h05, 8'h80, 8'hff};
   logic [15:0] exp9 [4] = '{16'h01fe, 16'h0005, 16'h0000, 16'h0181};
   startup_cal dut (.*);
   afe_model afe (.autozero_active(autozero_active), .amp_offset_measured(amp_offset_measured));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 v = rdata;
      if (m != 16'h0000)
         check(v & m, e);
   endtask
   // irq comes from registers, so give the status update two edges to land
   task automatic temp_pulse(input logic [15:0] t);
      @(posedge clk);
      temperature <= t;
      temperature_valid <= 1;
      @(posedge clk);
      temperature_valid <= 0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic print_verdict;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   // auto-zero alone needs about 161k cycles; the ceiling leaves margin
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 250000)
      begin
         n_mismatch++;
         print_verdict;
      end
   end
   initial
   begin
      reset = 1;
      {wr, rd, temperature_valid} = 3'h0;
      addr = 8'h00;
      wdata = 16'h0000;
      temperature = 16'h0000;
      repeat (10) @(posedge clk);
      reset <= 0;
      wr_reg(`OFS_VOFS, 16'h00a5);
      wr_reg(`OFS_TOFS, 16'h003c);
      wr_reg(`OFS_TGAIN, 16'h00c3);
      rd_chk(`OFS_VOFS, 16'h00a5, 16'hffff);
      check({voltage_offset_compensation, temperature_offset_compensation}, 16'ha53c);
      check({8'h00, temperature_gain_compensation}, 16'h00c3);
      rd_chk(8'h10, 16'h0000, 16'hffff);
      wr_reg(`OFS_COMPENSATION_CONTROL, 16'h0001);
      rd_chk(`OFS_COMPENSATION_CONTROL, 16'h0000, 16'h0001);
      for (i = 0; i < 4; i++)
      begin
         wr_reg(`OFS_ADJ_IN, {8'h00, adj[i]});
         rd_chk(`OFS_ADJ_OUT, exp9[i], 16'h01ff);
      end
      wr_reg(`OFS_ADJ_IN, 16'h0082);
      rd_chk(`OFS_ADJ_OUT, 16'h01fe, 16'h01ff);
      check({7'h00, 9'($signed(v[8:0]) >>> 1)}, 16'h01ff);
      wr_reg(`OFS_TEMP_MAX, 16'h0100);
      wr_reg(`OFS_TEMP_MIN, 16'h0080);
      wr_reg(`OFS_IRQ_MASK, 16'h0002);
      temp_pulse(16'h0090);
      check({15'h0, irq}, 16'h0000);
      temp_pulse(16'h0200);
      check({15'h0, irq}, 16'h0001);
      rd_chk(`OFS_IRQ_STAT, 16'h0002, 16'h0003);
      wr_reg(`OFS_IRQ_STAT, 16'h0002);
      temp_pulse(16'h0040);
      check({15'h0, irq}, 16'h0001);
      wr_reg(`OFS_IRQ_STAT, 16'h0002);
      wr_reg(`OFS_IRQ_MASK, 16'h0000);
      temp_pulse(16'h0200);
      check({15'h0, irq}, 16'h0000);
      rd_chk(`OFS_IRQ_STAT, 16'h0002, 16'h0003);
      wr_reg(`OFS_IRQ_STAT, 16'h0002);
      wr_reg(`OFS_IRQ_MASK, 16'h0001);
      wr_reg(`OFS_COMPENSATION_CONTROL, 16'h0101);
      t0 = cycles;
      repeat (2) @(posedge clk);
      #1 check({15'h0, autozero_active}, 16'h0001);
      v = 16'h0000;
      for (i = 0; i < 1000 && v[0] !== 1'b1; i++)
      begin
         repeat (200) @(posedge clk);
         rd_chk(`OFS_COMP_STAT, 16'h0000, 16'h0000);
      end
      check({15'h0, (cycles - t0) > 160700 && (cycles - t0) < 161400}, 16'h0001);
      check({15'h0, irq}, 16'h0001);
      for (i = 0; i < 8; i++)
         rd_chk(8'(`OFS_RESULT_BASE + i), 16'h02a5, 16'h07ff);
      wr_reg(`OFS_COMPENSATION_CONTROL, 16'h0100);
      rd_chk(`OFS_COMPENSATION_CONTROL, 16'h0000, 16'h0001);
      wr_reg(`OFS_COMP_STAT, 16'h0001);
      rd_chk(`OFS_COMP_STAT, 16'h0000, 16'h0001);
      wr_reg(`OFS_IRQ_STAT, 16'h0001);
      repeat (2) @(posedge clk);
      #1 check({15'h0, irq}, 16'h0000);
      print_verdict;
   end
endmodule
